// ---- pkg/acs_consts.vh ----
// timing constants for the converter phase sequencer
`ifndef ACS_CONSTS_VH
`define ACS_CONSTS_VH
`define ACS_SYS_CLK_KHZ      25000
`define ACS_OSC_KHZ          20000
`define ACS_OSC_DIV          5
`define ACS_PEAK_KSPS        250
// base period in divided-clock ticks: (osc/div)/peak rate
`define ACS_BASE_TICKS       ((`ACS_OSC_KHZ / `ACS_OSC_DIV) / `ACS_PEAK_KSPS)
`define ACS_SETTLE_US        10
`define ACS_CONV_US          3
`define ACS_SMP_TM_US        29
`define ACS_TICKS_PER_US     ((`ACS_OSC_KHZ / `ACS_OSC_DIV) / 1000)
`define ACS_SETTLE_TICKS     (`ACS_SETTLE_US * `ACS_TICKS_PER_US)
`define ACS_CONV_TICKS       (`ACS_CONV_US * `ACS_TICKS_PER_US)
`define ACS_SMP_TM_TICKS     (`ACS_SMP_TM_US * `ACS_TICKS_PER_US)
`define ACS_TM_MIN_RATE      3
`define ACS_RESULT_W         10
`define ACS_SEL_W            4
`endif

// ---- logic/acs_sequencer.v ----
// converter phase sequencer: settle, sample, convert and idle timing
`timescale 1ns/1ns
// Overview of operation
// - phase lengths are counted in ticks of the fast oscillator rate divided by five.
// - no conversion starts sooner than one peak-rate period after the previous one.
// - in normal modes sampling lasts two to the n base periods minus the three microsecond conversion.
// - a ten microsecond settling phase precedes every single conversion and only the first continuous one.
// - in temperature mode sampling is fixed at twenty-nine microseconds and the rate select changes only idle.
// - temperature idle is two to the n base periods minus sampling and conversion for n of three and up, else zero.
// - temperature conversions run at no more than one eighth of the peak rate.
// - idle is zero for a single temperature conversion and for continuous conversion at peak rate.
// - the continuous temperature period spans thirty-two to five hundred twelve microseconds.
// - each conversion yields a ten-bit result from the converter core.
// - exactly one selected input is routed to the converter during each sampling phase.
`include "acs_consts.vh"
module acs_sequencer #(
    parameter RESULT_W = `ACS_RESULT_W,
    parameter SEL_W    = `ACS_SEL_W
) (
    // clock and reset
    input  wire                SYS_CLK,
    input  wire                RSTN,
    // control from the processor side
    input  wire                START,
    input  wire                STOP,
    input  wire                CONTINUOUS,
    input  wire                TEMP_MODE,
    input  wire [2:0]          SAMPLE_RATE_SELECT,
    input  wire [SEL_W-1:0]    INPUT_SELECT,
    // converter core
    input  wire [RESULT_W-1:0] CORE_RESULT,
    output reg                 SAMPLE_EN,
    output reg                 CONVERT_EN,
    output reg                 SELECTOR_EN,
    output reg  [SEL_W-1:0]    SELECTOR_CHANNEL,
    // status and result
    output reg                 BUSY,
    output reg                 DONE,
    output reg  [RESULT_W-1:0] RESULT
);

    // phase states; idle also stands for a stopped or finished run
    localparam ST_IDLE   = 3'h0;
    localparam ST_SETTLE = 3'h1;
    localparam ST_SAMPLE = 3'h2;
    localparam ST_CONV   = 3'h3;
    localparam ST_GAP    = 3'h4;

    // phase lengths in divided-clock ticks, sixteen ticks to one base period
    localparam [15:0] BASE_T   = `ACS_BASE_TICKS;
    localparam [15:0] SETTLE_T = `ACS_SETTLE_TICKS;
    localparam [15:0] CONV_T   = `ACS_CONV_TICKS;
    localparam [15:0] SMPTM_T  = `ACS_SMP_TM_TICKS;
    localparam [2:0]  TM_MIN   = `ACS_TM_MIN_RATE;

    // divider from system clock to the divided oscillator rate
    // the system clock is no integer multiple of the divided rate, so a plain
    // counter would drift; the accumulator keeps the long-run rate exact at
    // the cost of one clock of jitter on each tick
    localparam integer DIV_NUM = `ACS_OSC_KHZ / `ACS_OSC_DIV;
    localparam integer DIV_DEN = `ACS_SYS_CLK_KHZ;

    // latched configuration and phase bookkeeping
    reg  [15:0] acc_q;
    reg         tick_q;
    reg  [2:0]  state_q;
    reg  [15:0] cnt_q;
    reg  [2:0]  rate_q;
    reg         cont_q;
    reg         temp_q;
    reg  [SEL_W-1:0] chan_q;
    reg         stop_q;
    wire [15:0] period_t;
    wire [15:0] smp_t;
    wire [15:0] gap_t;
    wire        last;

    // fractional accumulator gives 4 MHz average enables from 25 MHz
    always @(posedge SYS_CLK) begin
        if (!RSTN) begin
            acc_q  <= 16'h0000;
            tick_q <= 1'b0;
        end else if (acc_q + DIV_NUM[15:0] >= DIV_DEN[15:0]) begin
            acc_q  <= acc_q + DIV_NUM[15:0] - DIV_DEN[15:0];
            tick_q <= 1'b1;
        end else begin
            acc_q  <= acc_q + DIV_NUM[15:0];
            tick_q <= 1'b0;
        end
    end

    // phase lengths derived from the latched rate select
    assign period_t = BASE_T << rate_q;
    assign smp_t    = temp_q ? SMPTM_T : (period_t - CONV_T);
    // the rate select only stretches the gap in temperature mode
    // a clamp keeps temperature mode at no less than eight base periods
    assign gap_t    = (!temp_q) ? 16'h0000 :
                      (rate_q < TM_MIN) ? 16'h0000 :
                      (period_t - SMPTM_T - CONV_T);
    // the phase ends on the tick that finds one left, so a load of n gives n ticks
    assign last     = (cnt_q <= 16'h0001);

    // phase sequencer; phases advance on divided-clock enables, while start and a stop in the gap act at once
    // reset clears every phase output so the core never sees a stale enable
    always @(posedge SYS_CLK) begin
        if (!RSTN) begin
            state_q          <= ST_IDLE;
            cnt_q            <= 16'h0000;
            rate_q           <= 3'h0;
            cont_q           <= 1'b0;
            temp_q           <= 1'b0;
            chan_q           <= {SEL_W{1'b0}};
            stop_q           <= 1'b0;
            SAMPLE_EN        <= 1'b0;
            CONVERT_EN       <= 1'b0;
            SELECTOR_EN      <= 1'b0;
            SELECTOR_CHANNEL <= {SEL_W{1'b0}};
            BUSY             <= 1'b0;
            DONE             <= 1'b0;
            RESULT           <= {RESULT_W{1'b0}};
        end else begin
            // done is a one-cycle pulse, raised again only by the conversion end
            DONE <= 1'b0;
            // stop request held until the current cycle ends
            if (STOP && state_q != ST_IDLE)
                stop_q <= 1'b1;
            case (state_q)
                ST_IDLE: begin
                    // configuration is latched only here, so a mid-run change waits
                    stop_q <= 1'b0;
                    if (START) begin
                        rate_q  <= SAMPLE_RATE_SELECT;
                        cont_q  <= CONTINUOUS;
                        temp_q  <= TEMP_MODE;
                        chan_q  <= INPUT_SELECT;
                        cnt_q   <= SETTLE_T;
                        BUSY    <= 1'b1;
                        state_q <= ST_SETTLE;
                    end
                end
                ST_SETTLE: begin
                    // settling happens once per run; continuous cycles skip it
                    if (tick_q) begin
                        if (last) begin
                            cnt_q            <= smp_t;
                            SELECTOR_CHANNEL <= chan_q;
                            SELECTOR_EN      <= 1'b1;
                            SAMPLE_EN        <= 1'b1;
                            state_q          <= ST_SAMPLE;
                        end else begin
                            cnt_q <= cnt_q - 16'h0001;
                        end
                    end
                end
                ST_SAMPLE: begin
                    // selector and sampling enables drop together at the end
                    if (tick_q) begin
                        if (last) begin
                            cnt_q       <= CONV_T;
                            SAMPLE_EN   <= 1'b0;
                            SELECTOR_EN <= 1'b0;
                            CONVERT_EN  <= 1'b1;
                            state_q     <= ST_CONV;
                        end else begin
                            cnt_q <= cnt_q - 16'h0001;
                        end
                    end
                end
                ST_CONV: begin
                    // result taken on the last tick, while the core still holds it
                    if (tick_q) begin
                        if (last) begin
                            CONVERT_EN <= 1'b0;
                            RESULT     <= CORE_RESULT;
                            DONE       <= 1'b1;
                            if (!cont_q || stop_q || STOP) begin
                                // single temperature conversion has no idle phase
                                BUSY    <= 1'b0;
                                state_q <= ST_IDLE;
                            end else if (gap_t == 16'h0000) begin
                                cnt_q            <= smp_t;
                                SELECTOR_CHANNEL <= chan_q;
                                SELECTOR_EN      <= 1'b1;
                                SAMPLE_EN        <= 1'b1;
                                state_q          <= ST_SAMPLE;
                            end else begin
                                cnt_q   <= gap_t;
                                state_q <= ST_GAP;
                            end
                        end else begin
                            cnt_q <= cnt_q - 16'h0001;
                        end
                    end
                end
                ST_GAP: begin
                    // a stop in the gap ends the run at once: nothing is in flight
                    if (stop_q || STOP) begin
                        BUSY    <= 1'b0;
                        state_q <= ST_IDLE;
                    end else if (tick_q) begin
                        if (last) begin
                            cnt_q            <= smp_t;
                            SELECTOR_CHANNEL <= chan_q;
                            SELECTOR_EN      <= 1'b1;
                            SAMPLE_EN        <= 1'b1;
                            state_q          <= ST_SAMPLE;
                        end else begin
                            cnt_q <= cnt_q - 16'h0001;
                        end
                    end
                end
                default: begin
                    // unused codes fall back to idle rather than lock up
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

endmodule // acs_sequencer

// ---- testbench/acs_sequencer_chk_assertions.sv ----
// port checker for the converter phase sequencer
`timescale 1ns/1ns
module acs_sequencer_chk #(
    parameter RESULT_W = 10,
    parameter SEL_W    = 4
) (
    // clock and reset
    input wire logic                SYS_CLK,
    input wire logic                RSTN,
    // converter side
    input wire logic [RESULT_W-1:0] CORE_RESULT,
    input wire logic                SAMPLE_EN,
    input wire logic                CONVERT_EN,
    input wire logic                SELECTOR_EN,
    // status
    input wire logic                DONE,
    input wire logic [RESULT_W-1:0] RESULT
);
    logic [9:0]  cnv_q;
    logic [15:0] gap_q;
    logic        se_q;
    logic        rstn_q;
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RSTN);
    // phase counters; gap starts saturated so the first sample after reset is free
    always @(posedge SYS_CLK) begin
        cnv_q <= (!RSTN || !CONVERT_EN) ? 10'h0 : cnv_q + 10'h1;
        gap_q <= !RSTN ? 16'hffff : (SAMPLE_EN && !se_q) ? 16'h1 : gap_q + {15'h0, gap_q != 16'hffff};
        se_q  <= RSTN && SAMPLE_EN;
        rstn_q <= RSTN;
    end
    // rstn_q masks the first edge after reset, where history is still pre-reset
    property p_sel; SAMPLE_EN == SELECTOR_EN; endproperty
    property p_smp_cnv; rstn_q && $fell(SAMPLE_EN) |-> CONVERT_EN; endproperty
    property p_cnv_len; rstn_q && $fell(CONVERT_EN) |-> cnv_q inside {[74:76]}; endproperty
    property p_done; rstn_q && $fell(CONVERT_EN) |-> DONE; endproperty
    property p_pulse; DONE |=> !DONE; endproperty
    property p_res; DONE |-> RESULT == $past(CORE_RESULT); endproperty
    property p_hold; rstn_q && !DONE |-> $stable(RESULT); endproperty
    property p_gap; $rose(SAMPLE_EN) |-> gap_q >= 16'd98; endproperty
    a_sel: assert property (p_sel) else $error("selector not aligned with sampling");
    a_smp_cnv: assert property (p_smp_cnv) else $error("sampling not followed by conversion");
    a_cnv_len: assert property (p_cnv_len) else $error("conversion phase length wrong");
    a_done: assert property (p_done) else $error("no done at end of conversion");
    a_pulse: assert property (p_pulse) else $error("done longer than one cycle");
    a_res: assert property (p_res) else $error("result not taken from core");
    a_hold: assert property (p_hold) else $error("result moved without done");
    a_gap: assert property (p_gap) else $error("samples closer than peak rate");
    c_done: cover property (DONE);
    c_back: cover property ($rose(SAMPLE_EN) && gap_q < 16'h0100);
    c_cnv: cover property ($fell(CONVERT_EN));
endmodule // acs_sequencer_chk

// ---- testbench/acs_core_model.sv ----
// behavioural converter core that answers the sequencer
`timescale 1ns/1ns
module acs_core_model (
    // clock and sequencer controls
    input  wire logic       SYS_CLK,
    input  wire logic       CONVERT_EN,
    input  wire logic       SELECTOR_EN,
    input  wire logic [3:0] SELECTOR_CHANNEL,
    // result to the sequencer
    output wire logic [9:0] CORE_RESULT
);
    logic [9:0] res_q = 10'h0;
    // value tracks the routed channel; outside sampling and conversion the output wanders every cycle
    always @(posedge SYS_CLK) begin
        if (SELECTOR_EN) res_q <= {6'h2d, SELECTOR_CHANNEL};
        else if (!CONVERT_EN) res_q <= ~res_q ^ 10'h155;
    end
    assign CORE_RESULT = res_q;
endmodule // acs_core_model

// ---- testbench/acs_sequencer_tb.sv ----
// self-checking bench for the converter phase sequencer
`timescale 1ns/1ns
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin failures++; $display("unexpected %s exp %0d got %0d", nm, e, g); end end
module acs_sequencer_tb;
    logic       clk = 0, rstn = 0, start = 0, stop = 0, cont = 0, temp = 0, se_d = 0;
    logic [2:0] rate = 3'h0;
    logic [3:0] chan = 4'h0;
    wire  [9:0] core_res, res;
    wire  [3:0] sel_ch;
    wire        smp, cnv, sel_en, busy, done;
    int         failures = 0, compares = 0, cyc = 0, tb0, k;
    int         ts[$], tf[$];
    // continuous, temperature, rate, expected sample ticks (single) or period ticks (continuous)
    int rows[8][4] = '{'{0,0,0,4}, '{0,0,1,20}, '{0,0,7,2036}, '{0,1,0,116}, '{0,1,6,116},
                       '{1,1,4,256}, '{1,0,0,16}, '{1,1,0,128}};
    acs_sequencer i_acs_sequencer (.SYS_CLK(clk), .RSTN(rstn), .START(start), .STOP(stop), .CONTINUOUS(cont),
        .TEMP_MODE(temp), .SAMPLE_RATE_SELECT(rate), .INPUT_SELECT(chan), .CORE_RESULT(core_res), .SAMPLE_EN(smp),
        .CONVERT_EN(cnv), .SELECTOR_EN(sel_en), .SELECTOR_CHANNEL(sel_ch), .BUSY(busy), .DONE(done), .RESULT(res));
    acs_core_model i_acs_core_model (.SYS_CLK(clk), .CONVERT_EN(cnv), .SELECTOR_EN(sel_en),
        .SELECTOR_CHANNEL(sel_ch), .CORE_RESULT(core_res));
    // clocks to ticks, rounded, because the fractional divider jitters by a clock
    function automatic int tk(int c); return (c * 4 + 12) / 25; endfunction
    // start is not tick aligned: the first tick lands one to seven clocks after it
    function automatic bit near(int c, int t); return c * 4 > (t - 1) * 25 && c * 4 < (t - 1) * 25 + 40; endfunction
    task automatic final_report;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial forever #20 clk = ~clk;
    // edge times of the sampling phase
    always @(posedge clk) begin
        cyc  <= cyc + 1;
        se_d <= smp;
        if (smp === 1'b1 && se_d === 1'b0) ts.push_back(cyc);
        if (smp === 1'b0 && se_d === 1'b1) tf.push_back(cyc);
    end
    initial begin
        // all tests together take about 25000 clocks
        repeat (60000) @(posedge clk);
        failures++;
        final_report();
    end
    initial begin
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        `CHK("idle", 1'b0, busy | smp | cnv | done)
        foreach (rows[i]) begin
            @(posedge clk);
            ts.delete();
            tf.delete();
            start <= 1'b1;
            cont <= rows[i][0][0];
            temp <= rows[i][1][0];
            rate <= rows[i][2][2:0];
            chan <= i[3:0];
            @(posedge clk);
            start <= 1'b0;
            tb0 = cyc;
            for (k = 0; k < 30000 && (rows[i][0] ? ts.size() < 3 : done !== 1'b1); k++) @(posedge clk);
            if (rows[i][0]) begin
                stop <= 1'b1;
                `CHK("period", rows[i][3], tk(ts[1] - ts[0]))
                `CHK("period_again", rows[i][3], tk(ts[2] - ts[1]))
                for (k = 0; k < 30000 && busy !== 1'b0; k++) @(posedge clk);
                stop <= 1'b0;
            end else begin
                `CHK("sample", rows[i][3], tk(tf[0] - ts[0]))
                `CHK("result", {6'h2d, i[3:0]}, res)
            end
            `CHK("settle", 1'b1, near(ts[0] - tb0, 40))
            `CHK("busy_end", 1'b0, busy)
            $display("row %0d done", i);
        end
        // configuration changed after start must not reach the running cycle
        ts.delete();
        tf.delete();
        cont  <= 1'b0;
        temp  <= 1'b0;
        rate  <= 3'h1;
        chan  <= 4'h7;
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        rate  <= 3'h7;
        temp  <= 1'b1;
        chan  <= 4'h3;
        for (k = 0; k < 30000 && done !== 1'b1; k++) @(posedge clk);
        `CHK("late_cfg", 20, tk(tf[0] - ts[0]))
        `CHK("late_cfg_res", {6'h2d, 4'h7}, res)
        $display("config hold test done");
        // reset in the middle of a run clears every phase
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        repeat (300) @(posedge clk);
        rstn <= 1'b0;
        @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        `CHK("mid_reset", 1'b0, busy | smp | cnv)
        $display("reset test done");
        final_report();
    end
endmodule // acs_sequencer_tb
bind acs_sequencer acs_sequencer_chk #(.RESULT_W(RESULT_W), .SEL_W(SEL_W)) i_acs_sequencer_chk (.SYS_CLK(SYS_CLK),
    .RSTN(RSTN), .CORE_RESULT(CORE_RESULT), .SAMPLE_EN(SAMPLE_EN), .CONVERT_EN(CONVERT_EN),
    .SELECTOR_EN(SELECTOR_EN), .DONE(DONE), .RESULT(RESULT));
